/* design/fbc_bank_control.sv */
// Functional notes
// - Matrix columns hold extended registers in order
// - Bank select swaps front and extended banks
// - Transfer size picks single or pair moves
// - Precision bit picks single or double operations
// - Denormal bit one flushes denormals to zero
// - Cause bits seventeen down to twelve
// - Enable bits eleven down to seven
// - Flag bits six down to two
// - Each operation first clears whole cause field
// - Exception sets matching cause and flag bits
// - Flags stay set until software clears them
// - Rounding: zero nearest, one toward zero
// - Reserved status bits read and write zero
// - Status resets to 0x00040001
// - Thirty-two bit word between CPU and FPU
// - Doubles pair, vectors group consecutive singles
`timescale 1ns/1ps
`default_nettype none

module fbc_bank_control
(
    input  wire logic                   clk,            // Core clock
    input  wire logic                   rst,            // Sync reset
    // Register read port
    input  wire logic                   rd_req,         // Read request pulse
    input  wire fbc_pkg::fbc_view_t     rd_view,        // Front or extended
    input  wire logic [3:0]             rd_index,       // Single index
    input  wire fbc_pkg::fbc_width_t    rd_width,       // Width when not a move
    input  wire logic                   rd_move,        // Width from size mode
    output logic [127:0]                rd_data,        // Read result
    output logic                        rd_valid,       // Result strobe
    // Register write port
    input  wire logic                   wr_en,          // Write pulse
    input  wire fbc_pkg::fbc_view_t     wr_view,        // Front or extended
    input  wire logic [3:0]             wr_index,       // Single index
    input  wire logic                   wr_move,        // Move, else result
    input  wire logic [63:0]            wr_data,        // Even word high
    // Status/control access
    input  wire logic                   status_wr,      // System load pulse
    input  wire logic [31:0]            status_wdata,   // Load value
    input  wire logic                   bank_toggle,    // Bank change pulse
    output logic [31:0]                 fp_status_control,
    // Exception reporting
    input  wire logic                   op_start,       // Operation pulse
    input  wire fbc_pkg::fbc_exc_t      op_sources,     // Raised sources
    // CPU transfer word
    input  wire logic                   xfer_cpu_wr,    // System load pulse
    input  wire logic [31:0]            xfer_cpu_wdata, // CPU value
    input  wire logic                   xfer_fpu_wr,    // Conversion result
    input  wire logic [31:0]            xfer_fpu_wdata, // FPU value
    output logic [31:0]                 fp_cpu_transfer,
    // Decoded modes
    output logic                        bank_select,
    output logic                        transfer_size_mode,
    output logic                        precision_mode,
    output logic                        denormal_mode,
    output logic [1:0]                  rounding_mode,
    output logic [4:0]                  exc_enable,     // Invalid down to inexact
    output var fbc_pkg::fbc_matrix_t    extended_matrix
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fbc_pkg::fbc_state_t s;             // Registered state
    fbc_pkg::fbc_state_t next_s;        // Next state

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Physical bank behind a view
    function automatic logic phys_bank(input fbc_pkg::fbc_view_t view,
                                       input logic sel);
        phys_bank = (view == fbc_pkg::FBC_VIEW_EXT) ^ sel;
    endfunction

    // Even register of a pair
    function automatic logic [3:0] even_of(input logic [3:0] idx);
        even_of = {idx[3:1], 1'b0};
    endfunction

    // ------------------------------------------------------------------
    // Decoded fields
    // ------------------------------------------------------------------
    assign bank_select        = s.status[fbc_pkg::BIT_BANK_SELECT];
    assign transfer_size_mode = s.status[fbc_pkg::BIT_XFER_SIZE];
    assign precision_mode     = s.status[fbc_pkg::BIT_PRECISION];
    assign denormal_mode      = s.status[fbc_pkg::BIT_DENORMAL];
    // Reserved codes pass through; software must not write them
    assign rounding_mode      = s.status[fbc_pkg::RM_HI:fbc_pkg::RM_LO];
    assign exc_enable         = s.status[fbc_pkg::ENABLE_HI:fbc_pkg::ENABLE_LO];

    assign fp_status_control  = s.status;
    assign fp_cpu_transfer    = s.xfer;
    assign rd_data            = s.rd_data;
    assign rd_valid           = s.rd_valid;

    // ------------------------------------------------------------------
    // Matrix view of the extended bank
    // ------------------------------------------------------------------
    // Column c row r shows extended register 4c+r
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                extended_matrix[c][r] = s.bank[~bank_select][c*4+r];
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic        pb;        // Physical bank in use
        logic [3:0]  ev;        // Even pair index
        logic [3:0]  vb;        // Vector base index
        logic        pair;      // Write covers a pair
        fbc_pkg::fbc_width_t w; // Effective read width
        pb      = 1'b0;
        ev      = 4'h0;
        vb      = 4'h0;
        pair    = 1'b0;
        w       = fbc_pkg::FBC_W_SINGLE;
        next_s  = s;
        next_s.rd_valid = 1'b0;

        // Register read, answered one cycle later
        if (rd_req)
        begin
            pb = phys_bank(rd_view, bank_select);
            ev = even_of(rd_index);
            vb = {rd_index[3:2], 2'b00};
            // Moves follow the transfer size
            if (rd_move)
                w = transfer_size_mode ? fbc_pkg::FBC_W_DOUBLE
                                       : fbc_pkg::FBC_W_SINGLE;
            else
                w = rd_width;
            case (w)
                fbc_pkg::FBC_W_DOUBLE:
                    next_s.rd_data = {64'h0, s.bank[pb][ev],
                                      s.bank[pb][ev | 4'h1]};
                fbc_pkg::FBC_W_VECTOR:
                    next_s.rd_data = {s.bank[pb][vb], s.bank[pb][vb | 4'h1],
                                      s.bank[pb][vb | 4'h2],
                                      s.bank[pb][vb | 4'h3]};
                default:
                    next_s.rd_data = {96'h0, s.bank[pb][rd_index]};
            endcase
            next_s.rd_valid = 1'b1;
        end

        // Register write; pair for wide moves or double results
        if (wr_en)
        begin
            pb   = phys_bank(wr_view, bank_select);
            ev   = even_of(wr_index);
            pair = wr_move ? transfer_size_mode : precision_mode;
            if (pair)
            begin
                next_s.bank[pb][ev]        = wr_data[63:32];
                next_s.bank[pb][ev | 4'h1] = wr_data[31:0];
            end
            else
            begin
                next_s.bank[pb][wr_index] = wr_data[31:0];
            end
        end

        // Software load; reserved bits forced to zero
        if (status_wr)
            next_s.status = status_wdata & fbc_pkg::STATUS_MASK;

        // One-cycle bank swap
        if (bank_toggle)
            next_s.status[fbc_pkg::BIT_BANK_SELECT] =
                ~next_s.status[fbc_pkg::BIT_BANK_SELECT];

        // Operation: cause replaced, flags accumulate.
        // Applied after the load so a raised flag survives a clear.
        if (op_start)
        begin
            next_s.status[fbc_pkg::CAUSE_HI:fbc_pkg::CAUSE_LO] =
                op_sources;
            next_s.status[fbc_pkg::FLAG_HI:fbc_pkg::FLAG_LO] =
                next_s.status[fbc_pkg::FLAG_HI:fbc_pkg::FLAG_LO]
                | op_sources[4:0];
        end

        // Transfer word; the CPU load wins a same-cycle clash
        if (xfer_cpu_wr)
            next_s.xfer = xfer_cpu_wdata;
        else if (xfer_fpu_wr)
            next_s.xfer = xfer_fpu_wdata;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Banks and transfer word have no defined reset; cleared for safety
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s        <= '0;
            s.status <= fbc_pkg::STATUS_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_word: assert property ($past(rst) |-> s.status == 32'h0004_0001)
        else $error("status word wrong after reset");

    a_reserved_zero: assert property (s.status[31:22] == 10'h000)
        else $error("reserved status bits not zero");

    a_cause_replace: assert property (op_start |=> s.status[17:12] == $past(op_sources))
        else $error("cause field not replaced by sources");

    a_flag_set: assert property (op_start |=>
                                  (s.status[6:2] & $past(op_sources[4:0]))
                                  == $past(op_sources[4:0]))
        else $error("raised source missing from flags");

    a_flag_sticky: assert property (!op_start && !status_wr |=> $stable(s.status[6:2]))
        else $error("flags changed without cause");

    a_front_read: assert property (rd_req && !rd_move
                                   && rd_width == fbc_pkg::FBC_W_SINGLE
                                   |=> rd_valid && rd_data[31:0] ==
                                   $past(s.bank[(rd_view == fbc_pkg::FBC_VIEW_EXT)
                                               ^ bank_select][rd_index]))
        else $error("single read from wrong bank");

    a_pair_move: assert property (wr_en && wr_move && transfer_size_mode
                                  |=> s.bank[$past(phys_bank(wr_view, bank_select))]
                                      [$past(even_of(wr_index)) | 4'h1]
                                      == $past(wr_data[31:0]))
        else $error("pair move did not write odd register");

    a_double_result: assert property (wr_en && !wr_move && precision_mode
                                      |=> s.bank[$past(phys_bank(wr_view, bank_select))]
                                          [$past(even_of(wr_index))]
                                          == $past(wr_data[63:32]))
        else $error("double result did not write even register");

    a_matrix_order: assert property (extended_matrix[1][2] ==
                                     (bank_select ? s.bank[0][6] : s.bank[1][6]))
        else $error("matrix element out of column order");

    a_xfer_load: assert property (xfer_cpu_wr |=> fp_cpu_transfer == $past(xfer_cpu_wdata))
        else $error("transfer word not loaded");

    a_toggle_swap: assert property (bank_toggle && !status_wr
                                    |=> bank_select != $past(bank_select))
        else $error("bank toggle did not swap");

    // Conversion result only lands when the CPU stays quiet
    a_fpu_xfer: assert property (xfer_fpu_wr && !xfer_cpu_wr
                                 |=> fp_cpu_transfer == $past(xfer_fpu_wdata))
        else $error("conversion result not loaded");

    // Narrow move touches only the addressed register
    a_single_move: assert property (wr_en && wr_move && !transfer_size_mode
                                    |=> s.bank[$past(phys_bank(wr_view, bank_select))]
                                        [$past(wr_index)] == $past(wr_data[31:0]))
        else $error("single move missed addressed register");

    // Vector read starts at the group base, even for odd indices
    a_vector_base: assert property (rd_req && !rd_move
                                    && rd_width == fbc_pkg::FBC_W_VECTOR
                                    |=> rd_data[127:96] ==
                                        $past(s.bank[phys_bank(rd_view, bank_select)]
                                                    [{rd_index[3:2], 2'b00}]))
        else $error("vector read not based on group");

    // Plain load keeps only the defined fields
    a_status_load: assert property (status_wr && !bank_toggle && !op_start
                                    |=> fp_status_control ==
                                        ($past(status_wdata) & fbc_pkg::STATUS_MASK))
        else $error("status load not masked");

    c_vector_read: cover property (rd_req && rd_width == fbc_pkg::FBC_W_VECTOR ##1 rd_valid);
    c_flag_clash:  cover property (op_start && status_wr && op_sources.ovf);
    c_bank_swap:   cover property (bank_toggle ##2 rd_req);
    c_pair_move:   cover property (wr_en && wr_move && transfer_size_mode);

endmodule

`default_nettype wire

/* design/fbc_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants and types for the FPU register bank control block
// ----------------------------------------------------------------------
package fbc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_BANKS = 2;               // Physical banks
    localparam int BANK_REGS = 16;              // Single registers per bank
    localparam int WORD_W    = 32;              // Single register width

    // ------------------------------------------------------------------
    // Status/control word layout
    // ------------------------------------------------------------------
    localparam int BIT_BANK_SELECT  = 21;       // Front/extended swap
    localparam int BIT_XFER_SIZE    = 20;       // Move size, pair when set
    localparam int BIT_PRECISION    = 19;       // Double precision when set
    localparam int BIT_DENORMAL     = 18;       // Flush denormals when set
    localparam int CAUSE_HI         = 17;       // Error source, cause only
    localparam int CAUSE_LO         = 12;       // Inexact cause
    localparam int ENABLE_HI        = 11;       // Invalid enable
    localparam int ENABLE_LO        = 7;        // Inexact enable
    localparam int FLAG_HI          = 6;        // Invalid flag
    localparam int FLAG_LO          = 2;        // Inexact flag
    localparam int RM_HI            = 1;        // Rounding mode msb
    localparam int RM_LO            = 0;        // Rounding mode lsb

    localparam logic [31:0] STATUS_RESET = 32'h0004_0001;  // Power-up word
    localparam logic [31:0] STATUS_MASK  = 32'h003F_FFFF;  // Writable bits

    // Rounding encodings
    localparam logic [1:0] RM_NEAREST = 2'h0;   // Round to nearest
    localparam logic [1:0] RM_ZERO    = 2'h1;   // Round toward zero

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Access width of a register read
    typedef enum logic [1:0] {
        FBC_W_SINGLE,
        FBC_W_DOUBLE,
        FBC_W_VECTOR
    } fbc_width_t;

    // Register view: front or extended
    typedef enum logic {
        FBC_VIEW_FRONT,
        FBC_VIEW_EXT
    } fbc_view_t;

    // Physical storage, bank then register
    typedef logic [NUM_BANKS-1:0][BANK_REGS-1:0][WORD_W-1:0] fbc_banks_t;

    // Matrix view, column then row
    typedef logic [3:0][3:0][WORD_W-1:0] fbc_matrix_t;

    // Exception sources, error down to inexact
    typedef struct packed {
        logic err;
        logic inv;
        logic dz;
        logic ovf;
        logic unf;
        logic inx;
    } fbc_exc_t;

    // Whole block state
    typedef struct packed {
        fbc_banks_t         bank;       // Both physical banks
        logic [31:0]        status;     // Status/control word
        logic [31:0]        xfer;       // CPU transfer word
        logic [127:0]       rd_data;    // Registered read result
        logic               rd_valid;   // Read result strobe
    } fbc_state_t;

endpackage

/* dv/fbc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// CPU side: one request per call, launched and released at falling edges
// ----------------------------------------------------------------------
// Ports grouped by type to keep the model short
module fbc_cpu_model
(
    input  wire logic                clk,
    input  wire logic [127:0]        rd_data,
    input  wire logic                rd_valid,
    output logic                     rd_req, rd_move,
    output var fbc_pkg::fbc_view_t   rd_view, wr_view,
    output var fbc_pkg::fbc_width_t  rd_width,
    output logic [3:0]               rd_index, wr_index,
    output logic                     wr_en, wr_move, status_wr, bank_toggle, op_start,
    output logic [63:0]              wr_data,
    output logic [31:0]              status_wdata, xfer_cpu_wdata, xfer_fpu_wdata,
    output var fbc_pkg::fbc_exc_t    op_sources,
    output logic                     xfer_cpu_wr, xfer_fpu_wr
);
    // Idle levels from time zero
    initial
    begin
        {rd_req, rd_move, wr_en, wr_move, status_wr, bank_toggle} = 6'h00;
        {op_start, xfer_cpu_wr, xfer_fpu_wr, rd_index, wr_index} = 11'h000;
        {wr_data, status_wdata, op_sources, xfer_cpu_wdata, xfer_fpu_wdata} = '0;
        rd_view = fbc_pkg::FBC_VIEW_FRONT;
        wr_view = fbc_pkg::FBC_VIEW_FRONT;
        rd_width = fbc_pkg::FBC_W_SINGLE;
    end
    // Read; answer taken one cycle after the request
    task automatic rd(input fbc_pkg::fbc_view_t v, input logic [3:0] i,
                      input fbc_pkg::fbc_width_t w, input logic mv,
                      output logic [127:0] d, output logic ok);
        @(negedge clk);
        rd_req = 1'b1;
        rd_view = v;
        rd_index = i;
        rd_width = w;
        rd_move = mv;
        @(negedge clk);
        d = rd_data;
        ok = rd_valid;
        rd_req = 1'b0;
        rd_index = ~i;
    endtask
    // Write; released data lines show the inverse, not a stale copy
    task automatic wr(input fbc_pkg::fbc_view_t v, input logic [3:0] i,
                      input logic mv, input logic [63:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_view = v;
        wr_index = i;
        wr_move = mv;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    // Status load, bank flip, operation; raw skips the software limits
    task automatic ctl(input logic sw, input logic [31:0] w, input logic raw, input logic tg,
                       input logic os, input fbc_pkg::fbc_exc_t s);
        logic [31:0] m;
        m = w & 32'h003F_FFFD;
        if (m[20])
            m[19] = 1'b0;
        @(negedge clk);
        status_wdata = raw ? w : m;
        status_wr = sw;
        bank_toggle = tg;
        op_start = os;
        op_sources = s;
        @(negedge clk);
        {status_wr, bank_toggle, op_start} = 3'h0;
        status_wdata = ~status_wdata;
        op_sources = ~s;
    endtask
    // Transfer word from either side
    task automatic xfer(input logic c, input logic f, input logic [31:0] dc,
                        input logic [31:0] df);
        @(negedge clk);
        xfer_cpu_wr = c;
        xfer_fpu_wr = f;
        xfer_cpu_wdata = dc;
        xfer_fpu_wdata = df;
        @(negedge clk);
        {xfer_cpu_wr, xfer_fpu_wr} = 2'h0;
        {xfer_cpu_wdata, xfer_fpu_wdata} = ~{dc, df};
    endtask
endmodule
`default_nettype wire

/* dv/test_fpu_register_bank_control.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench: CPU model drives the block, expectations from the bit layout
// ----------------------------------------------------------------------
module test_fpu_register_bank_control;
    logic clk, rst, rd_req, rd_move, rd_valid, wr_en, wr_move, status_wr, bank_toggle;
    logic op_start, xfer_cpu_wr, xfer_fpu_wr, bank_select, transfer_size_mode;
    logic precision_mode, denormal_mode;
    logic [1:0] rounding_mode;
    logic [4:0] exc_enable;
    logic [3:0] rd_index, wr_index;
    logic [31:0] status_wdata, fp_status_control, xfer_cpu_wdata, xfer_fpu_wdata;
    logic [31:0] fp_cpu_transfer, exp_st, fa, xa;
    logic [63:0] wr_data;
    logic [127:0] rd_data;
    logic [5:0] src;
    fbc_pkg::fbc_view_t rd_view, wr_view;
    fbc_pkg::fbc_width_t rd_width;
    fbc_pkg::fbc_exc_t op_sources;
    fbc_pkg::fbc_matrix_t extended_matrix;
    int fails, samples_checked, i, p;
    // Short aliases for views and widths
    localparam fbc_pkg::fbc_view_t v_front = fbc_pkg::FBC_VIEW_FRONT;
    localparam fbc_pkg::fbc_view_t v_ext = fbc_pkg::FBC_VIEW_EXT;
    localparam fbc_pkg::fbc_width_t w_one = fbc_pkg::FBC_W_SINGLE;
    localparam fbc_pkg::fbc_width_t w_two = fbc_pkg::FBC_W_DOUBLE;
    localparam fbc_pkg::fbc_width_t w_four = fbc_pkg::FBC_W_VECTOR;
    fbc_bank_control uut
    (
        .clk(clk), .rst(rst), .rd_req(rd_req), .rd_view(rd_view), .rd_index(rd_index),
        .rd_width(rd_width), .rd_move(rd_move), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_en(wr_en), .wr_view(wr_view), .wr_index(wr_index), .wr_move(wr_move),
        .wr_data(wr_data), .status_wr(status_wr), .status_wdata(status_wdata),
        .bank_toggle(bank_toggle), .fp_status_control(fp_status_control),
        .op_start(op_start), .op_sources(op_sources), .xfer_cpu_wr(xfer_cpu_wr),
        .xfer_cpu_wdata(xfer_cpu_wdata), .xfer_fpu_wr(xfer_fpu_wr),
        .xfer_fpu_wdata(xfer_fpu_wdata), .fp_cpu_transfer(fp_cpu_transfer),
        .bank_select(bank_select), .transfer_size_mode(transfer_size_mode),
        .precision_mode(precision_mode), .denormal_mode(denormal_mode),
        .rounding_mode(rounding_mode), .exc_enable(exc_enable),
        .extended_matrix(extended_matrix)
    );
    fbc_cpu_model cpu
    (
        .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_req(rd_req),
        .rd_move(rd_move), .rd_view(rd_view), .wr_view(wr_view), .rd_width(rd_width),
        .rd_index(rd_index), .wr_index(wr_index), .wr_en(wr_en), .wr_move(wr_move),
        .status_wr(status_wr), .bank_toggle(bank_toggle), .op_start(op_start),
        .wr_data(wr_data), .status_wdata(status_wdata), .xfer_cpu_wdata(xfer_cpu_wdata),
        .xfer_fpu_wdata(xfer_fpu_wdata), .op_sources(op_sources),
        .xfer_cpu_wr(xfer_cpu_wr), .xfer_fpu_wr(xfer_fpu_wr)
    );
    // 25 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare with case equality so unknowns never match
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Read and expect the strobe high with the data, both sampled once
    task automatic rdc(input fbc_pkg::fbc_view_t v, input int x, input fbc_pkg::fbc_width_t w,
                       input logic mv, input logic [127:0] exp);
        logic [127:0] d;
        logic ok;
        cpu.rd(v, x[3:0], w, mv, d, ok);
        chk({127'h0, ok}, 128'h1, "read strobe");
        chk(d, exp, "read data");
    endtask
    // Counts, verdict, end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Run is a few hundred cycles; cut a hang after 5000
    initial
    begin
        #(40 * 5000);
        fails++;
        close_out();
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        fails = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(fp_status_control, 32'h0004_0001, "reset word");
        chk({bank_select, transfer_size_mode, precision_mode}, 3'h0, "modes");
        chk({denormal_mode, rounding_mode}, 3'h5, "flush, round");
        $display("test reset done");
        // Distinct words in every physical cell
        for (i = 0; i < 16; i++)
        begin
            cpu.wr(v_front, i[3:0], 1'b0, {32'h0, 32'hA000_0000 + i});
            cpu.wr(v_ext, i[3:0], 1'b0, {32'h0, 32'hB000_0000 + i});
        end
        // Both bank settings; second flip brings bank 0 back
        for (p = 0; p < 2; p++)
        begin
            chk(bank_select, p[0], "bank select");
            for (i = 0; i < 16; i++)
            begin
                fa = (p == 0 ? 32'hA000_0000 : 32'hB000_0000) + i;
                xa = (p == 0 ? 32'hB000_0000 : 32'hA000_0000) + i;
                rdc(v_front, i, w_one, 1'b0, fa);
                rdc(v_ext, i, w_one, 1'b0, xa);
                chk(extended_matrix[i / 4][i % 4], xa, "matrix cell");
            end
            cpu.ctl(1'b0, 32'h0, 1'b0, 1'b1, 1'b0, 6'h00);
        end
        $display("test banks done");
        // Odd index still selects the even-based pair or group
        rdc(v_front, 5, w_two, 1'b0, 64'hA000_0004_A000_0005);
        rdc(v_ext, 14, w_two, 1'b0, 64'hB000_000E_B000_000F);
        rdc(v_ext, 11, w_four, 1'b0, {64'hB000_0008_B000_0009, 64'hB000_000A_B000_000B});
        rdc(v_front, 3, w_two, 1'b1, 32'hA000_0003);
        cpu.ctl(1'b1, 32'h0014_0001, 1'b0, 1'b0, 1'b0, 6'h00);
        rdc(v_front, 3, w_one, 1'b1, 64'hA000_0002_A000_0003);
        cpu.wr(v_front, 4'h3, 1'b1, 64'hC000_0002_C000_0003);
        rdc(v_front, 2, w_two, 1'b0, 64'hC000_0002_C000_0003);
        cpu.ctl(1'b1, 32'h0008_0001, 1'b0, 1'b0, 1'b0, 6'h00);
        cpu.wr(v_front, 4'h7, 1'b0, 64'hD000_0006_D000_0007);
        cpu.wr(v_front, 4'h9, 1'b1, 64'hEEEE_EEEE_E000_0009);
        rdc(v_front, 6, w_two, 1'b0, 64'hD000_0006_D000_0007);
        rdc(v_front, 8, w_two, 1'b0, 64'hA000_0008_E000_0009);
        $display("test pairs done");
        // Reserved bits and reserved rounding code 3
        cpu.ctl(1'b1, 32'hFFFF_FFFF, 1'b1, 1'b0, 1'b0, 6'h00);
        chk(fp_status_control, 32'h003F_FFFF, "reserved bits");
        chk({bank_select, transfer_size_mode, precision_mode, denormal_mode}, 4'hF, "modes");
        chk({rounding_mode, exc_enable}, 7'h7F, "round, enables");
        for (p = 0; p < 2; p++)
        begin
            cpu.ctl(1'b1, 32'h0000_0F80 | p, 1'b0, 1'b0, 1'b0, 6'h00);
            chk({denormal_mode, rounding_mode}, p[2:0], "round code");
        end
        $display("test status done");
        // Each source alone, then none; flags accumulate
        exp_st = 32'h0000_0F81;
        for (i = 0; i <= 6; i++)
        begin
            src = (i == 6) ? 6'h00 : 6'h01 << i;
            cpu.ctl(1'b0, 32'h0, 1'b0, 1'b0, 1'b1, src);
            exp_st[17:12] = src;
            exp_st[6:2] = exp_st[6:2] | src[4:0];
            chk(fp_status_control, exp_st, "cause, flags");
        end
        cpu.ctl(1'b1, 32'h0000_0F81, 1'b0, 1'b0, 1'b1, 6'h04);
        chk(fp_status_control, 32'h0000_4F91, "load with op");
        $display("test exceptions done");
        cpu.xfer(1'b1, 1'b0, 32'h1234_5678, 32'h0);
        chk(fp_cpu_transfer, 32'h1234_5678, "cpu load");
        cpu.xfer(1'b0, 1'b1, 32'h0, 32'h9ABC_DEF0);
        chk(fp_cpu_transfer, 32'h9ABC_DEF0, "fpu load");
        cpu.xfer(1'b1, 1'b1, 32'h0F0F_0F0F, 32'hF0F0_F0F0);
        chk(fp_cpu_transfer, 32'h0F0F_0F0F, "clash");
        $display("test transfer done");
        close_out();
    end
endmodule
`default_nettype wire
